/* logic/dsbi_pkg.sv */
// Constants, types and codes of the differential serial bus interface.
// Assumes one core clock; all pins are synchronised in the top module.
package dsbi_pkg;

// ==========================================================
// Mode decode, index {mode pin, chip select pin}
// ==========================================================
localparam logic [1:0] PIN_ASYNC = 2'h3;
localparam logic [1:0] PIN_SPI   = 2'h2;
localparam logic [1:0] PIN_BUF   = 2'h0;
localparam logic [1:0] PIN_TRI   = 2'h1;

typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_SPI   = 2'b01,
    MODE_BUF   = 2'b10,
    MODE_TRI   = 2'b11
} dsbi_mode_e;

// ==========================================================
// Clock divider, index {A pin, B pin}
// ==========================================================
localparam logic [3:0] DIV_00 = 4'h1;
localparam logic [3:0] DIV_01 = 4'h2;
localparam logic [3:0] DIV_10 = 4'h4;
localparam logic [3:0] DIV_11 = 4'ha;

// ==========================================================
// Bit timing in internal clock ticks
// ==========================================================
localparam logic [6:0] BIT_LAST  = 7'h7f;
localparam logic [6:0] HALF_LAST = 7'h3f;
localparam logic [6:0] SCK_RISE  = 7'h04;
localparam logic [6:0] SCK_FALL  = 7'h24;
localparam logic [2:0] DATA_LAST = 3'h7;
localparam logic [3:0] TX_STOP   = 4'h9;
localparam logic [3:0] TX_LAST   = 4'h9;
localparam logic [3:0] TX_D_LAST = 4'h8;
localparam int         EOM_BITS  = 10;

// ==========================================================
// Reset values
// ==========================================================
localparam logic [15:0] BUF_RST  = 16'h0000;
localparam logic        IDLE_RST = 1'b1;

typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
} dsbi_rx_e;

typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b10
} dsbi_tx_e;

// Synchronised pin levels
typedef struct packed {
    logic       mode;
    logic       cs_n;
    logic [1:0] div;
    logic       tx;
    logic       sck;
    logic       ctrl;
    logic       idle_n;
    logic       bus;
} dsbi_pins_s;

endpackage

/* logic/dsbi_top.sv */
// Differential serial bus interface: host UART/SPI side to wired bus.
// Assumes an external transceiver: bus_rx_i is 1 for a recessive bus,
// bus_drv_p/n enables drive a dominant zero. Two-way pins are split.
//
// Behaviour
// - Mode from mode and chip-select pins: 11 async, 10 SPI, 00 buffered, 01 off from buffered, else mode held.
// - Three-state entered only from buffered SPI when chip select rises.
// - Three-state floats host data, receive output and shift clock only.
// - Bus value seen is returned to host while its byte is sent.
// - Async mode checks each received character for a framing error.
// - Normal SPI: device drives one shift clock per data bit at bus rate.
// - Host pulls control low to request sending; device starts on it.
// - Normal SPI: reflected bus byte replaces the byte the host sent.
// - Buffered SPI: host clocks a 16-bit two-byte buffer.
// - Buffered SPI sends only once the bus is idle.
// - Buffered send overwrites both bytes with reflected ones.
// - Clock divided by 1, 2, 4 or 10 by the select pins.
// - One bus bit lasts 128 internal clock ticks.
// - Shift clock unused async, output normal SPI, input buffered SPI.
// - Idle pin low when bus idle after end of message, high active.
// - Async and SPI: control low while a byte is on the bus.
// - Buffered: control high means host may use the buffer.
// - Zero drives both lines, one releases both.
// - Dominant zero wins; idle bus reads one.
// - Characters are start, eight data bits LSB first, stop.
// - Bit mismatch blocks host data until message end.
`timescale 1ns/10ps
module dsbi_top #(
    parameter int EOM_BITS = dsbi_pkg::EOM_BITS
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    // Mode and divider straps
    input  wire logic       mode_i,
    input  wire logic       cs_n_i,
    input  wire logic [1:0] div_sel_i,
    // Host data
    input  wire logic       host_tx_data_in_i,
    output logic            host_rx_data_out_o,
    output logic            host_rx_data_out_oe_o,
    // Shift clock pin
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_o,
    // Control pin
    input  wire logic       ctrl_i,
    output logic            ctrl_o,
    output logic            ctrl_oe_o,
    // Idle pin, low while bus idle
    input  wire logic       idle_n_i,
    output logic            idle_n_o,
    output logic            idle_n_oe_o,
    // Transceiver
    input  wire logic       bus_rx_i,
    output logic            bus_drv_p_o,
    output logic            bus_drv_n_o,
    // Status
    output logic            frame_err_o
);

localparam int EOM_TICKS = EOM_BITS * 128;
localparam int EW        = $clog2(EOM_TICKS + 1);
localparam logic [EW-1:0] EOM_LAST = EW'(EOM_TICKS - 1);

// ==========================================================
// Input synchronisers
// ==========================================================
dsbi_pkg::dsbi_pins_s pin_m;
dsbi_pkg::dsbi_pins_s pin_s;
logic                 bus_d;
logic                 sck_d;

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        pin_m <= '1;
        pin_s <= '1;
        bus_d <= 1'b1;
        sck_d <= 1'b0;
    end else begin
        pin_m <= {mode_i, cs_n_i, div_sel_i, host_tx_data_in_i,
                  sck_i, ctrl_i, idle_n_i, bus_rx_i};
        pin_s <= pin_m;
        bus_d <= pin_s.bus;
        sck_d <= pin_s.sck;
    end
end

// Own pin levels two cycles back, aligned with the synchronised pins.
// Without them a pin we just released still reads low for two cycles.
logic [1:0] ctrl_hist;
logic [1:0] idle_hist;

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ctrl_hist <= 2'b11;
        idle_hist <= 2'b00;
    end else begin
        ctrl_hist <= {ctrl_hist[0], ctrl_o};
        idle_hist <= {idle_hist[0], idle_n_o};
    end
end

// ==========================================================
// Mode
// ==========================================================
dsbi_pkg::dsbi_mode_e mode;
dsbi_pkg::dsbi_mode_e next_mode;

always_comb begin
    next_mode = mode;
    unique case ({pin_s.mode, pin_s.cs_n})
        dsbi_pkg::PIN_ASYNC: next_mode = dsbi_pkg::MODE_ASYNC;
        dsbi_pkg::PIN_SPI:   next_mode = dsbi_pkg::MODE_SPI;
        dsbi_pkg::PIN_BUF:   next_mode = dsbi_pkg::MODE_BUF;
        dsbi_pkg::PIN_TRI: begin
            if (mode == dsbi_pkg::MODE_BUF)
                next_mode = dsbi_pkg::MODE_TRI;
        end
    endcase
end

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
        mode <= dsbi_pkg::MODE_ASYNC;
    else
        mode <= next_mode;
end

wire is_async = (mode == dsbi_pkg::MODE_ASYNC);
wire is_spi   = (mode == dsbi_pkg::MODE_SPI);
wire is_buf   = (mode == dsbi_pkg::MODE_BUF);
wire is_tri   = (mode == dsbi_pkg::MODE_TRI);

// ==========================================================
// Clock divider
// ==========================================================
logic [3:0] div_cnt;
logic [3:0] div_max;
logic       tick;

always_comb begin
    unique case (pin_s.div)
        2'b00: div_max = dsbi_pkg::DIV_00 - 4'h1;
        2'b01: div_max = dsbi_pkg::DIV_01 - 4'h1;
        2'b10: div_max = dsbi_pkg::DIV_10 - 4'h1;
        2'b11: div_max = dsbi_pkg::DIV_11 - 4'h1;
    endcase
end

assign tick = (div_cnt >= div_max);

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
        div_cnt <= 4'h0;
    else if (tick)
        div_cnt <= 4'h0;
    else
        div_cnt <= div_cnt + 4'h1;
end

// ==========================================================
// Bus receiver
// ==========================================================
dsbi_pkg::dsbi_rx_e rx_state;
logic [6:0]         rx_cnt;
logic [2:0]         rx_idx;
logic               rx_bit;
logic               frame_err;
wire                bus_fall = bus_d & ~pin_s.bus;
wire                rx_end = tick & (rx_cnt == dsbi_pkg::BIT_LAST);

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        rx_state  <= dsbi_pkg::RX_IDLE;
        rx_cnt    <= 7'h00;
        rx_idx    <= 3'h0;
        rx_bit    <= 1'b1;
        frame_err <= 1'b0;
    end else begin
        if (tick)
            rx_cnt <= rx_cnt + 7'h01;
        unique case (rx_state)
            dsbi_pkg::RX_IDLE: begin
                if (bus_fall) begin
                    rx_state <= dsbi_pkg::RX_START;
                    rx_cnt   <= 7'h00;
                end
            end
            dsbi_pkg::RX_START: begin
                if (tick && rx_cnt == dsbi_pkg::HALF_LAST) begin
                    rx_cnt   <= 7'h00;
                    rx_idx   <= 3'h0;
                    rx_state <= pin_s.bus ? dsbi_pkg::RX_IDLE
                                          : dsbi_pkg::RX_DATA;
                end
            end
            dsbi_pkg::RX_DATA: begin
                if (rx_end) begin
                    rx_bit <= pin_s.bus;
                    rx_idx <= rx_idx + 3'h1;
                    if (rx_idx == dsbi_pkg::DATA_LAST)
                        rx_state <= dsbi_pkg::RX_STOP;
                end
            end
            dsbi_pkg::RX_STOP: begin
                if (rx_end) begin
                    frame_err <= ~pin_s.bus;
                    rx_state  <= dsbi_pkg::RX_IDLE;
                end
            end
        endcase
    end
end

wire rx_busy = (rx_state != dsbi_pkg::RX_IDLE);

// ==========================================================
// End of message and idle
// ==========================================================
logic [EW-1:0] eom_cnt;
logic          bus_idle;
// host break seen while we drive the pin high
wire           brk = ~pin_s.idle_n & idle_hist[1];

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        eom_cnt  <= '0;
        bus_idle <= dsbi_pkg::IDLE_RST;
    end else if (rx_busy || !pin_s.bus || brk) begin
        eom_cnt  <= '0;
        bus_idle <= 1'b0;
    end else if (tick && !bus_idle) begin
        // quiet bus for the end gap
        if (eom_cnt == EOM_LAST)
            bus_idle <= 1'b1;
        else
            eom_cnt <= eom_cnt + {{(EW-1){1'b0}}, 1'b1};
    end
end

// ==========================================================
// Collision block
// ==========================================================
dsbi_pkg::dsbi_tx_e tx_state;
logic               tx_bit;
logic               blocked;
wire                sending = is_async | (tx_state == dsbi_pkg::TX_SEND);
wire                own_bit = is_async ? pin_s.tx : tx_bit;

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
        blocked <= 1'b0;
    else if (bus_idle)
        blocked <= 1'b0;
    // mismatch blocks until end of message
    else if (rx_end && rx_state == dsbi_pkg::RX_DATA &&
             sending && own_bit != pin_s.bus)
        blocked <= 1'b1;
end

// ==========================================================
// SPI transmitter
// ==========================================================
logic [6:0]  tx_cnt;
logic [3:0]  tx_idx;
logic        tx_byte;
logic [15:0] buf_q;
// host pulls control low against our high
wire         req = (is_spi | is_buf) & ctrl_o & ctrl_hist[1] & ~pin_s.ctrl;
localparam logic [3:0] TX_LAST_I = dsbi_pkg::TX_STOP;

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        tx_state <= dsbi_pkg::TX_IDLE;
        tx_cnt   <= 7'h00;
        tx_idx   <= 4'h0;
        tx_bit   <= 1'b1;
        tx_byte  <= 1'b0;
    end else if (blocked) begin
        tx_state <= dsbi_pkg::TX_IDLE;
        tx_bit   <= 1'b1;
    end else begin
        unique case (tx_state)
            dsbi_pkg::TX_IDLE: begin
                if (req)
                    tx_state <= dsbi_pkg::TX_WAIT;
            end
            dsbi_pkg::TX_WAIT: begin
                if (tick && (is_spi ? !rx_busy : bus_idle)) begin
                    tx_state <= dsbi_pkg::TX_SEND;
                    tx_cnt   <= 7'h00;
                    tx_idx   <= 4'h0;
                    tx_byte  <= 1'b0;
                    tx_bit   <= 1'b0;
                end
            end
            dsbi_pkg::TX_SEND: begin
                if (tick)
                    tx_cnt <= tx_cnt + 7'h01;
                if (tick && tx_cnt == dsbi_pkg::BIT_LAST) begin
                    tx_idx <= tx_idx + 4'h1;
                    if (tx_idx == TX_LAST_I) begin
                        tx_idx <= 4'h0;
                        tx_bit <= 1'b0;
                        tx_byte <= 1'b1;
                        if (!is_buf || tx_byte) begin
                            tx_state <= dsbi_pkg::TX_IDLE;
                            tx_bit   <= 1'b1;
                        end
                    end else if (tx_idx == dsbi_pkg::TX_D_LAST)
                        tx_bit <= 1'b1;
                    else
                        tx_bit <= is_spi ? pin_s.tx : buf_q[15];
                end
            end
            default: tx_state <= dsbi_pkg::TX_IDLE;
        endcase
    end
end

// ==========================================================
// Two-byte buffer
// ==========================================================
// host clocks bits in while it owns the buffer
wire host_shift = (is_buf | is_tri) & ctrl_o & pin_s.sck & ~sck_d;
// reflected bits replace the sent ones
wire bus_shift  = (is_buf | is_tri) & rx_end &
                  (rx_state == dsbi_pkg::RX_DATA);

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
        buf_q <= dsbi_pkg::BUF_RST;
    else if (bus_shift)
        buf_q <= {buf_q[14:0], pin_s.bus};
    else if (host_shift && is_buf)
        buf_q <= {buf_q[14:0], pin_s.tx};
end

// ==========================================================
// Pin drivers
// ==========================================================
logic next_rx;
logic next_sck;
logic next_ctrl;
logic next_drv;
wire  spi_clk_win = (rx_state == dsbi_pkg::RX_STOP) ||
                    (rx_state == dsbi_pkg::RX_DATA && rx_idx != 3'h0);

always_comb begin
    unique case (mode)
        dsbi_pkg::MODE_ASYNC: next_rx = pin_s.bus;
        dsbi_pkg::MODE_SPI:   next_rx = rx_bit;
        dsbi_pkg::MODE_BUF:   next_rx = buf_q[15];
        dsbi_pkg::MODE_TRI:   next_rx = 1'b1;
    endcase
    // one pulse after each sampled bit
    next_sck = is_spi & spi_clk_win &
               (rx_cnt >= dsbi_pkg::SCK_RISE) &
               (rx_cnt < dsbi_pkg::SCK_FALL);
    // low while a byte is on the bus
    next_ctrl = ~rx_busy & (tx_state != dsbi_pkg::TX_SEND);
    // high only when buffer is free
    if (is_buf || is_tri)
        next_ctrl = (tx_state == dsbi_pkg::TX_IDLE) & ~rx_busy;
    next_drv = brk | (~blocked & (is_async ? ~pin_s.tx
              : (tx_state == dsbi_pkg::TX_SEND) & ~tx_bit));
end

always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        // bus released, idle low, control high
        host_rx_data_out_o    <= 1'b1;
        host_rx_data_out_oe_o <= 1'b0;
        sck_o                 <= 1'b0;
        sck_oe_o              <= 1'b0;
        ctrl_o                <= 1'b1;
        ctrl_oe_o             <= 1'b1;
        idle_n_o              <= 1'b0;
        idle_n_oe_o           <= 1'b1;
        bus_drv_p_o           <= 1'b0;
        bus_drv_n_o           <= 1'b0;
        frame_err_o           <= 1'b0;
    end else begin
        host_rx_data_out_o    <= next_rx;
        // float data and clock in three-state
        host_rx_data_out_oe_o <= ~is_tri;
        sck_o                 <= next_sck;
        // shift clock driven only in normal SPI
        sck_oe_o              <= is_spi;
        ctrl_o                <= next_ctrl;
        ctrl_oe_o             <= 1'b1;
        // low while the bus is idle
        idle_n_o              <= ~bus_idle;
        idle_n_oe_o           <= 1'b1;
        bus_drv_p_o           <= next_drv;
        bus_drv_n_o           <= next_drv;
        frame_err_o           <= frame_err & is_async;
    end
end

endmodule

/* tb/dsbi_props.sv */
// Checker for the bus interface: timing relations seen at the top pins.
// Assumes pins are held steady across mode changes and a 1x divider.
`timescale 1ns/10ps
module dsbi_props (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic mode_i,
    input wire logic cs_n_i,
    input wire logic host_tx_data_in_i,
    input wire logic host_rx_data_out_oe_o,
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic ctrl_i,
    input wire logic ctrl_o,
    input wire logic ctrl_oe_o,
    input wire logic idle_n_o,
    input wire logic idle_n_oe_o,
    input wire logic bus_rx_i,
    input wire logic bus_drv_p_o,
    input wire logic bus_drv_n_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (!arst_n_i);
// ==========================================================
// Sequences
sequence s_spi_req;
    mode_i && !cs_n_i && ctrl_o && !ctrl_i && bus_rx_i;
endsequence
sequence s_pulse;
    sck_o [*8];
endsequence
// ==========================================================
// Properties
// levels after reset
a_reset_levels: assert property ($rose(arst_n_i) |-> ctrl_o && !idle_n_o && !bus_drv_p_o)
    else $error("reset levels wrong");
a_drive_pair: assert property (bus_drv_p_o == bus_drv_n_o)
    else $error("bus lines driven apart");
a_ctrl_idle_oe: assert property (ctrl_oe_o && idle_n_oe_o)
    else $error("control or idle pin floated");
a_sck_owner: assert property ($rose(sck_oe_o) |-> mode_i && !cs_n_i)
    else $error("shift clock driven outside normal spi");
a_sck_in_spi: assert property (sck_o |-> sck_oe_o)
    else $error("shift clock pulse while not driven");
a_sck_width: assert property ($rose(sck_o) |-> s_pulse)
    else $error("shift clock pulse too short");
a_tri_float: assert property ($fell(host_rx_data_out_oe_o) |-> !mode_i && cs_n_i && !$past(cs_n_i, 8))
    else $error("receive output floated outside three-state");
a_spi_start: assert property (s_spi_req |-> ##[1:16] bus_drv_p_o)
    else $error("control request did not start a byte");
a_async_pass: assert property (mode_i && cs_n_i && !idle_n_o && $fell(host_tx_data_in_i) |-> ##3 bus_drv_p_o)
    else $error("host start bit not passed to bus");
a_ctrl_busy: assert property ($rose(bus_drv_p_o) && mode_i |-> ##[1:16] !ctrl_o)
    else $error("control stayed high during a byte");
a_idle_quiet: assert property ($fell(idle_n_o) |-> bus_rx_i && $past(bus_rx_i, 8))
    else $error("idle reported on an active bus");
endmodule

bind dsbi_top dsbi_props u_props (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .mode_i(mode_i), .cs_n_i(cs_n_i),
    .host_tx_data_in_i(host_tx_data_in_i), .host_rx_data_out_oe_o(host_rx_data_out_oe_o),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ctrl_i(ctrl_i), .ctrl_o(ctrl_o), .ctrl_oe_o(ctrl_oe_o),
    .idle_n_o(idle_n_o), .idle_n_oe_o(idle_n_oe_o), .bus_rx_i(bus_rx_i),
    .bus_drv_p_o(bus_drv_p_o), .bus_drv_n_o(bus_drv_n_o));

/* tb/dsbi_far_model.sv */
// Far side: wired bus with one other node, host pull-downs on shared pins.
// Assumes pull-ups on control and idle; bias gives a recessive bus.
`timescale 1ns/10ps
module dsbi_far_model (
    // Device side
    input  wire logic drv_p_i,
    input  wire logic drv_n_i,
    input  wire logic ctrl_v_i,
    input  wire logic ctrl_oe_i,
    input  wire logic idle_v_i,
    input  wire logic idle_oe_i,
    // Other node and host
    input  wire logic node_low_i,
    input  wire logic ctrl_low_i,
    input  wire logic idle_low_i,
    // Resolved levels
    output logic      bus_o,
    output logic      ctrl_o,
    output logic      idle_o
);
// ==========================================================
// Wire resolution
// any drive is a dominant zero
assign bus_o = !(drv_p_i || drv_n_i || node_low_i);
// host pulls the shared pins low
assign ctrl_o = (!ctrl_oe_i || ctrl_v_i) && !ctrl_low_i;
assign idle_o = (!idle_oe_i || idle_v_i) && !idle_low_i;
endmodule

/* tb/test_dsbi.sv */
// Self-checking bench for the bus interface: async, normal and buffered spi.
// Assumes the far side model resolves bus, control and idle levels.
`timescale 1ns/10ps
module test_differential_serial_bus_interface;
logic       mclk = 1'b0;
logic       arst_n = 1'b0;
logic       mode = 1'b1;
logic       cs_n = 1'b1;
logic [1:0] div = 2'h0;
logic       tx = 1'b1;
logic       sck_in = 1'b0;
logic       node_low = 1'b0;
logic       ctrl_low = 1'b0;
logic       idle_low = 1'b0;
logic       rx, rx_oe, sck, sck_oe, ctrl_v, ctrl_oe, idle_v, idle_oe;
logic       bus, ctrl, idle, drv_p, drv_n, ferr;
int         n_errors = 0;
int         n_checks = 0;

initial begin
    forever #2 mclk = ~mclk;
end

dsbi_top #(.EOM_BITS(2)) dut (
    .mclk_i(mclk), .arst_n_i(arst_n), .mode_i(mode), .cs_n_i(cs_n), .div_sel_i(div),
    .host_tx_data_in_i(tx), .host_rx_data_out_o(rx), .host_rx_data_out_oe_o(rx_oe),
    .sck_i(sck_in), .sck_o(sck), .sck_oe_o(sck_oe), .ctrl_i(ctrl), .ctrl_o(ctrl_v),
    .ctrl_oe_o(ctrl_oe), .idle_n_i(idle), .idle_n_o(idle_v), .idle_n_oe_o(idle_oe),
    .bus_rx_i(bus), .bus_drv_p_o(drv_p), .bus_drv_n_o(drv_n), .frame_err_o(ferr));

dsbi_far_model far (
    .drv_p_i(drv_p), .drv_n_i(drv_n), .ctrl_v_i(ctrl_v), .ctrl_oe_i(ctrl_oe),
    .idle_v_i(idle_v), .idle_oe_i(idle_oe), .node_low_i(node_low), .ctrl_low_i(ctrl_low),
    .idle_low_i(idle_low), .bus_o(bus), .ctrl_o(ctrl), .idle_o(idle));

// ==========================================================
// Shared tasks
task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
endtask

task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
endtask

task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask

task automatic wait_idle;
    int k;
    k = 0;
    while (idle_v !== 1'b0 && k < 4000) begin
        @(negedge mclk);
        k++;
    end
    check("idle", idle_v, 1'b0);
    cyc(1);
endtask

// Character from the host pin or from the other node, checked mid-bit
task automatic frame(input logic [7:0] d, input logic from_host, input int bl, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
        if (from_host) tx <= f[i];
        else node_low <= !f[i];
        cyc(bl / 2);
        @(negedge mclk);
        check("host_rx", rx, f[i]);
        if (from_host) check("drive", drv_p, !f[i]);
        cyc(bl - bl / 2);
    end
    tx <= 1'b1;
    node_low <= 1'b0;
endtask

// ==========================================================
// Scenarios
task automatic t_reset;
    @(negedge mclk);
    check("ctrl", ctrl_v, 1'b1);
    check("idle", idle_v, 1'b0);
    check("drive", drv_p, 1'b0);
    check("rx_oe", rx_oe, 1'b1);
    check("frame_err", ferr, 1'b0);
    cyc(1);
endtask

task automatic t_async_rx;
    frame(8'h00, 1'b0, 128, 1'b0);
    cyc(140);
    check("frame_err", ferr, 1'b1);
    wait_idle();
    // Zero data: a divider left at 1 would sample a data bit as stop
    div <= 2'h1;
    cyc(4);
    frame(8'h00, 1'b0, 256, 1'b1);
    cyc(100);
    check("frame_err", ferr, 1'b0);
    wait_idle();
    div <= 2'h0;
    cyc(4);
endtask

task automatic t_async_tx;
    frame(8'h55, 1'b1, 128, 1'b1);
    wait_idle();
endtask

task automatic t_spi;
    logic [7:0] got;
    logic       prev;
    int         n;
    int         k;
    got = 8'h00;
    prev = 1'b0;
    n = 0;
    k = 0;
    cs_n <= 1'b0;
    cyc(8);
    check("sck_oe", sck_oe, 1'b1);
    ctrl_low <= 1'b1;
    while (bus !== 1'b0 && k < 400) begin
        @(negedge mclk);
        k++;
    end
    cyc(1);
    ctrl_low <= 1'b0;
    for (int c = 0; c < 1320; c++) begin
        // other node wins bit 3, later host zeros must stay off
        if (c == 512) node_low <= 1'b1;
        if (c == 640) node_low <= 1'b0;
        if (c == 640) tx <= 1'b0;
        @(negedge mclk);
        if (c == 64) check("ctrl", ctrl_v, 1'b0);
        // host sees the first shifted bit as bit 0
        if (sck && !prev && n < 8) got[n[2:0]] = rx;
        if (sck && !prev) n++;
        prev = sck;
        cyc(1);
    end
    tx <= 1'b1;
    check("sck_pulses", n[15:0], 16'h0008);
    check("reflected", got, 8'hf7);
    check("ctrl_end", ctrl_v, 1'b1);
    wait_idle();
endtask

task automatic t_buf;
    logic [31:0] v;
    int          k;
    v = {16'ha5c3, 16'h0000};
    k = 0;
    // Mode low with chip select high from normal spi: not three-state
    mode <= 1'b0;
    cs_n <= 1'b1;
    cyc(8);
    check("rx_oe", rx_oe, 1'b1);
    cs_n <= 1'b0;
    cyc(8);
    check("sck_oe", sck_oe, 1'b0);
    check("ctrl", ctrl_v, 1'b1);
    for (int i = 0; i < 32; i++) begin
        if (i == 16) begin
            // two bytes loaded: request a send on the idle bus
            ctrl_low <= 1'b1;
            while (bus !== 1'b0 && k < 400) begin
                @(negedge mclk);
                k++;
            end
            cyc(1);
            ctrl_low <= 1'b0;
            while (ctrl_v !== 1'b1 && k < 4000) begin
                @(negedge mclk);
                k++;
            end
            check("buf_done", ctrl_v, 1'b1);
            cyc(1);
        end
        tx <= v[31 - i];
        cyc(6);
        @(negedge mclk);
        if (i >= 16) check("buffer_out", rx, v[47 - i]);
        cyc(1);
        sck_in <= 1'b1;
        cyc(6);
        sck_in <= 1'b0;
    end
    cs_n <= 1'b1;
    cyc(8);
    check("rx_oe", rx_oe, 1'b0);
    check("sck_oe", sck_oe, 1'b0);
endtask

// ==========================================================
// Sequence and watchdog
initial begin
    cyc(12);
    arst_n <= 1'b1;
    cyc(6);
    t_reset();
    t_async_rx();
    t_async_tx();
    t_spi();
    t_buf();
    report_and_stop();
end

initial begin
    // Tests take about 10000 cycles
    cyc(30000);
    n_errors++;
    report_and_stop();
end
endmodule
